// File: gige_tx_host_packet_port_tb.sv
// Bench joining host and device ends of the transmit host packet port
`timescale 1ns/1ps
`include "gtxhp_consts.svh"
module gige_tx_host_packet_port_tb
   import gtxhp_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic        usr_valid = 1'b0, usr_first = 1'b0, usr_last = 1'b0, usr_no_fcs = 1'b0, usr_pause = 1'b0;
   logic        usr_drop_clear = 1'b0, usr_reg_wr = 1'b0, usr_reg_rd = 1'b0;
   logic [31:0] usr_data = 32'h0;
   logic [3:0]  usr_byte_valid = 4'h0;
   logic [7:0]  usr_reg_addr = 8'h0;
   logic [15:0] usr_reg_wdata = 16'h0, usr_reg_rdata;
   logic        usr_level1, usr_level2, usr_dropped, line_valid, ign_q = 1'b0;
   logic [7:0]  line_byte;
   logic [31:0] lfsr_q = 32'h8866AE21, crc_q;
   logic [1:0]  rd_p = 2'h0;
   // Bit 8 marks the first lead-in byte of each frame
   logic [8:0]  exp_b[$], eb;
   gtxhp_lt_t   lt_kind;
   gtxhp_da_t   da_kind;
   logic [15:0] exp_r[$];
   int          err_total = 0, num_checks = 0, cnt_q, gap_q = 0, cyc = 0;
   always #4 clk_sys = ~clk_sys;
   gtxhp_if gtxhp_if_inst ();
   gtxhp_host gtxhp_host_inst (.clk_sys(clk_sys), .nrst(nrst), .port(gtxhp_if_inst.host), .usr_valid(usr_valid),
      .usr_data(usr_data), .usr_byte_valid(usr_byte_valid), .usr_first(usr_first), .usr_last(usr_last),
      .usr_no_fcs(usr_no_fcs), .usr_pause(usr_pause), .usr_drop_clear(usr_drop_clear), .usr_reg_wr(usr_reg_wr),
      .usr_reg_rd(usr_reg_rd), .usr_reg_addr(usr_reg_addr), .usr_reg_wdata(usr_reg_wdata),
      .usr_reg_rdata(usr_reg_rdata), .usr_level1(usr_level1), .usr_level2(usr_level2), .usr_dropped(usr_dropped));
   gtxhp_device gtxhp_device_inst (.clk_sys(clk_sys), .nrst(nrst), .port(gtxhp_if_inst.device),
      .line_valid(line_valid), .line_byte(line_byte), .frame_undersize(), .frame_oversize(), .frame_lt_kind(lt_kind),
      .frame_da_kind(da_kind));
   gtxhp_port_sva gtxhp_port_sva_inst (.clk_sys(clk_sys), .nrst(nrst), .tx_select_n(gtxhp_if_inst.tx_select_n),
      .tx_byte_valid(gtxhp_if_inst.tx_byte_valid), .tx_first_word(gtxhp_if_inst.tx_first_word),
      .tx_last_word(gtxhp_if_inst.tx_last_word), .tx_drop_flag_clear(gtxhp_if_inst.tx_drop_flag_clear),
      .tx_level_flag1_n(gtxhp_if_inst.tx_level_flag1_n), .tx_level_flag2_n(gtxhp_if_inst.tx_level_flag2_n),
      .tx_drop_flag(gtxhp_if_inst.tx_drop_flag), .reg_wr(gtxhp_if_inst.reg_wr), .reg_rd(gtxhp_if_inst.reg_rd),
      .reg_rdata(gtxhp_if_inst.reg_rdata));
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
      c = c ^ {24'h0, b};
      for (int i = 0; i < 8; i++)
         c = c[0] ? ((c >> 1) ^ `GTXHP_CRC_POLY) : (c >> 1);
      return c;
   endfunction
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin err_total++; $display("unexpected line byte: expected %h seen %h", e, g); end
   endtask
   task automatic chk_reg(input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin err_total++; $display("unexpected read data: expected %h seen %h", e, g); end
   endtask
   task automatic chk_flag(input string n, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin err_total++; $display("unexpected %s: expected %b seen %b", n, e, g); end
   endtask
   task automatic push_b(input logic [7:0] b);
      exp_b.push_back({1'b0, b});
      crc_q = crc_step(crc_q, b);
      cnt_q++;
   endtask
   task automatic lead_in();
      crc_q = `GTXHP_CRC_INIT;
      cnt_q = 0;
      exp_b.push_back({1'b1, `GTXHP_PRE_BYTE});
      repeat (6) exp_b.push_back({1'b0, `GTXHP_PRE_BYTE});
      exp_b.push_back({1'b0, `GTXHP_SFD_BYTE});
   endtask
   task automatic close_frame(input logic fcs);
      logic [31:0] c;
      while (cnt_q < 60) push_b(8'h00);
      c = ~crc_q;
      if (fcs) for (int i = 0; i < 4; i++) exp_b.push_back({1'b0, c[8*i +: 8]});
   endtask
   // Leaves the port selected so a following call runs back to back
   task automatic send_frame(input int nw, input logic [3:0] lbe, input logic nf, input logic big, input logic fcs);
      logic [31:0] w;
      logic [3:0]  be;
      lead_in();
      for (int i = 0; i < nw; i++) begin
         lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
         w = lfsr_q;
         be = (i == nw - 1) ? lbe : 4'hF;
         for (int k = 0; k < 4; k++)
            if (be[big ? 3 - k : k]) push_b(w[8 * (big ? 3 - k : k) +: 8]);
         usr_valid <= 1'b1;
         usr_data <= w;
         usr_byte_valid <= be;
         usr_first <= (i == 0);
         usr_last <= (i == nw - 1);
         usr_no_fcs <= nf;
         @(posedge clk_sys);
      end
      close_frame(fcs);
   endtask
   task automatic idle_drain();
      usr_valid <= 1'b0;
      usr_first <= 1'b0;
      usr_last <= 1'b0;
      @(posedge clk_sys);
      while (exp_b.size() != 0 || line_valid !== 1'b0) @(posedge clk_sys);
      repeat (16) @(posedge clk_sys);
   endtask
   task automatic reg_op(input logic wr, input logic [7:0] a, input logic [15:0] d);
      usr_reg_wr <= wr;
      usr_reg_rd <= !wr;
      usr_reg_addr <= a;
      usr_reg_wdata <= d;
      if (!wr) exp_r.push_back(d);
      @(posedge clk_sys);
      usr_reg_wr <= 1'b0;
      usr_reg_rd <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin err_total++; give_verdict(); end
      if (rd_p[1]) chk_reg(exp_r.size() ? exp_r.pop_front() : 16'hxxxx, usr_reg_rdata);
      rd_p <= {rd_p[0], usr_reg_rd};
      if (line_valid === 1'b1 && !ign_q) begin
         eb = exp_b.size() ? exp_b.pop_front() : 9'h0XX;
         // Only the gap before a lead-in counts; skipped lanes leave bubbles inside a frame
         if (eb[8] && gap_q > 0) chk_flag("gap", 1'b1, gap_q >= `GTXHP_IPG_BYTES);
         gap_q = 0;
         chk_byte(eb[7:0], line_byte);
      end else if (num_checks > 0) gap_q++;
   end
   initial begin
      logic [143:0] pz;
      repeat (6) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      reg_op(0, 8'h00, `GTXHP_CFG_RST);
      reg_op(0, 8'h01, 16'h0100);
      reg_op(0, 8'h02, 16'h0300);
      reg_op(0, 8'h03, 16'h0000);
      reg_op(0, 8'h87, 16'h0000);
      reg_op(0, 8'hC0, 16'h0000);
      send_frame(4, 4'hF, 1'b0, 1'b0, 1'b1);
      send_frame(17, 4'hA, 1'b1, 1'b0, 1'b1);
      idle_drain();
      for (int k = 0; k < 4; k++) begin
         reg_op(1, 8'h00, {13'h0, k == 2, 1'b1, k[1]});
         reg_op(0, 8'h00, {13'h0, k == 2, 1'b1, k[1]});
         send_frame(5, 4'h7, k[0], k == 2, k[1] | !k[0]);
         idle_drain();
      end
      pz = {`GTXHP_PAUSE_DA, 48'h0, `GTXHP_PAUSE_TYPE, `GTXHP_PAUSE_OP, `GTXHP_PAUSE_TIME};
      lead_in();
      for (int i = 0; i < 18; i++) push_b(pz[143 - 8 * i -: 8]);
      close_frame(1'b1);
      usr_pause <= 1'b1;
      @(posedge clk_sys);
      usr_pause <= 1'b0;
      idle_drain();
      chk_flag("address kind", 1'b1, da_kind == GTXHP_DA_MULTICAST);
      chk_flag("length kind", 1'b1, lt_kind == GTXHP_LT_TYPE);
      // Overrun needs far more words than the store holds since the line drains it meanwhile
      ign_q = 1'b1;
      send_frame(2000, 4'hF, 1'b0, 1'b0, 1'b1);
      usr_valid <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk_flag("dropped", 1'b1, usr_dropped);
      usr_drop_clear <= 1'b1;
      @(posedge clk_sys);
      usr_drop_clear <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk_flag("dropped", 1'b0, usr_dropped);
      give_verdict();
   end
endmodule

// File: gtxhp_consts.svh
// Constants for the transmit host packet port
`ifndef GTXHP_CONSTS_SVH
`define GTXHP_CONSTS_SVH
`define GTXHP_DATA_W        32
`define GTXHP_BE_W          4
`define GTXHP_FIFO_DEPTH    1024
`define GTXHP_PTR_W         10
`define GTXHP_CNT_W         11
`define GTXHP_WM1_RST       11'h100
`define GTXHP_WM2_RST       11'h300
`define GTXHP_MIN_FRAME     11'h040
`define GTXHP_MAX_FRAME     11'h5EE
`define GTXHP_MIN_DATA      11'h02E
`define GTXHP_LEN_MAX       16'h05DC
`define GTXHP_TYPE_MIN      16'h05EE
`define GTXHP_PRE_BYTE      8'h55
`define GTXHP_SFD_BYTE      8'hAB
`define GTXHP_PRE_BYTES     4'h7
`define GTXHP_HDR_BYTES     11'h00E
`define GTXHP_CRC_BYTES     11'h004
`define GTXHP_IPG_NS        96
`define GTXHP_BYTE_NS       8
`define GTXHP_IPG_BYTES     4'((`GTXHP_IPG_NS + `GTXHP_BYTE_NS - 1) / `GTXHP_BYTE_NS)
`define GTXHP_CRC_POLY      32'hEDB88320
`define GTXHP_CRC_INIT      32'hFFFFFFFF
`define GTXHP_CRC_RESIDUE   32'hFFFFFFFF
`define GTXHP_NREG_CFG      22
`define GTXHP_NREG_CNT      114
`define GTXHP_NREG          136
`define GTXHP_REG_AW        8
`define GTXHP_REG_CFG_IDX   8'h00
`define GTXHP_REG_WM1_IDX   8'h01
`define GTXHP_REG_WM2_IDX   8'h02
`define GTXHP_REG_STAT_IDX  8'h03
`define GTXHP_REG_CNT0_IDX  8'h16
`define GTXHP_CFG_FCS_BIT   0
`define GTXHP_CFG_PAD_BIT   1
`define GTXHP_CFG_BE_BIT    2
`define GTXHP_CFG_AUTO_BIT  3
`define GTXHP_CFG_RST       16'h0003
`define GTXHP_PAUSE_LEN     11'h03C
`define GTXHP_PAUSE_TYPE    16'h8808
`define GTXHP_PAUSE_OP      16'h0001
`define GTXHP_PAUSE_TIME    16'hFFFF
`define GTXHP_PAUSE_DA      48'h0180C2000001
`endif

// File: gtxhp_device.sv
// Device end of the transmit host packet port: FIFO, flags, registers, framing
`timescale 1ns/1ps
`include "gtxhp_consts.svh"
module gtxhp_device
   import gtxhp_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   gtxhp_if.device          port,
   output logic             line_valid,
   output logic [7:0]       line_byte,
   output logic             frame_undersize,
   output logic             frame_oversize,
   output gtxhp_lt_t        frame_lt_kind,
   output gtxhp_da_t        frame_da_kind
);
   localparam int DEPTH = `GTXHP_FIFO_DEPTH;

   // Each entry: frame check control, first, last, byte valid, data
   logic [38:0]  mem [DEPTH];
   logic [`GTXHP_PTR_W-1:0] wr_q, rd_q;
   logic [`GTXHP_CNT_W-1:0] used_q;
   logic [15:0]  regs_q [`GTXHP_NREG];
   logic [15:0]  rdata_q;
   logic         drop_q;
   logic         in_pkt_q;
   logic         bad_q;
   logic         pause_q;
   logic         fifo_push, fifo_pop, fifo_full, fifo_empty;
   logic [38:0]  head;
   logic [1:0]   lane_q;
   logic         f_start, f_ready, f_busy, f_last, f_valid;
   logic [7:0]   f_byte;
   logic         pause_run_q;
   logic [5:0]   pause_idx_q;
   logic [10:0]  flen_q;
   logic [15:0]  lt_q;
   logic         src_pause_q;
   logic         cfg_be;
   logic [3:0]   be_ord;

   function automatic logic [7:0] lane_of(input logic [31:0] w, input logic [1:0] n, input logic be);
      logic [1:0] k;
      k = be ? 2'(3 - n) : n;
      return w[k*8 +: 8];
   endfunction

   function automatic logic [7:0] pause_byte(input logic [5:0] i);
      logic [111:0] hdr;
      hdr = {`GTXHP_PAUSE_DA, 48'h000000000000, `GTXHP_PAUSE_TYPE};
      if (i < 6'd14) return hdr[8'(111 - 8*i) -: 8];
      if (i == 6'd14) return 8'(`GTXHP_PAUSE_OP >> 8);
      if (i == 6'd15) return 8'(`GTXHP_PAUSE_OP);
      if (i == 6'd16) return 8'(`GTXHP_PAUSE_TIME >> 8);
      if (i == 6'd17) return 8'(`GTXHP_PAUSE_TIME);
      return 8'h00;
   endfunction

   assign cfg_be     = regs_q[`GTXHP_REG_CFG_IDX][`GTXHP_CFG_BE_BIT];
   assign fifo_full  = (used_q == `GTXHP_CNT_W'(DEPTH));
   assign fifo_empty = (used_q == '0);
   // a selected edge writes unless the rest of its packet is being discarded; full drops instead
   assign fifo_push  = !port.tx_select_n && !fifo_full && !bad_q;
   assign head       = mem[rd_q];
   // Byte valids in send order, so lane_q counts lanes as they leave
   assign be_ord     = cfg_be ? {head[32], head[33], head[34], head[35]} : head[35:32];
   assign f_valid    = !src_pause_q && !fifo_empty && be_ord[lane_q];
   // A packet's last word leaves at its last valid lane, so the end marker rides a real byte
   assign fifo_pop   = !src_pause_q && f_ready && !fifo_empty
                       && (lane_q == 2'h3 || (head[36] && (be_ord >> lane_q) <= 4'h1));
   assign f_last     = src_pause_q ? (pause_idx_q == 6'(`GTXHP_PAUSE_LEN - 1)) : head[36];
   assign f_byte     = src_pause_q ? pause_byte(pause_idx_q) : lane_of(head[31:0], lane_q, cfg_be);
   assign f_start    = !f_busy && (pause_q || (!fifo_empty && head[37]));

   always_ff @(posedge clk_sys) begin
      if (fifo_push) begin
         mem[wr_q] <= {port.pkt_fcs_ctrl_n, port.tx_first_word, port.tx_last_word, port.tx_byte_valid,
                       port.tx_data};
      end
   end

   // Pause requests are held until the framer is free
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pause_q     <= 1'b0;
         src_pause_q <= 1'b0;
         pause_idx_q <= 6'h00;
      end else begin
         if (port.pause_request) pause_q <= 1'b1;
         else if (f_start) pause_q <= 1'b0;
         if (f_start) begin
            src_pause_q <= pause_q;
            pause_idx_q <= 6'h00;
         end else if (src_pause_q && f_ready) begin
            pause_idx_q <= pause_idx_q + 6'h01;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wr_q   <= '0;
         rd_q   <= '0;
         used_q <= '0;
         lane_q <= 2'h0;
      end else begin
         if (fifo_push) wr_q <= wr_q + 1'b1;
         if (fifo_pop) rd_q <= rd_q + 1'b1;
         used_q <= used_q + `GTXHP_CNT_W'(fifo_push) - `GTXHP_CNT_W'(fifo_pop);
         if (fifo_pop) lane_q <= 2'h0;
         else if (!src_pause_q && f_ready && !fifo_empty) lane_q <= lane_q + 2'h1;
      end
   end

   // Packet tracking: an overflow mid-packet discards the rest of it
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         in_pkt_q <= 1'b0;
         bad_q    <= 1'b0;
      end else if (!port.tx_select_n) begin
         if (port.tx_first_word) in_pkt_q <= !port.tx_last_word;
         else if (port.tx_last_word) in_pkt_q <= 1'b0;
         if (port.tx_last_word) bad_q <= 1'b0;
         else if (fifo_full && (in_pkt_q || port.tx_first_word)) bad_q <= 1'b1;
      end
   end

   // Set wins over clear
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         drop_q <= 1'b0;
      end else if (!port.tx_select_n && fifo_full && !bad_q) begin
         drop_q <= 1'b1;
      end else if (port.tx_drop_flag_clear
                   || (regs_q[`GTXHP_REG_CFG_IDX][`GTXHP_CFG_AUTO_BIT] && !port.tx_select_n
                       && port.tx_first_word)) begin
         drop_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         port.tx_level_flag1_n <= 1'b1;
         port.tx_level_flag2_n <= 1'b1;
      end else begin
         port.tx_level_flag1_n <= !(16'(used_q) > regs_q[`GTXHP_REG_WM1_IDX]);
         port.tx_level_flag2_n <= !(16'(used_q) > regs_q[`GTXHP_REG_WM2_IDX]);
      end
   end
   assign port.tx_drop_flag = drop_q;

   // Register file; counter region reads back but counting lives elsewhere
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < `GTXHP_NREG; i++) regs_q[i] <= 16'h0000;
         regs_q[`GTXHP_REG_CFG_IDX] <= `GTXHP_CFG_RST;
         regs_q[`GTXHP_REG_WM1_IDX] <= 16'(`GTXHP_WM1_RST);
         regs_q[`GTXHP_REG_WM2_IDX] <= 16'(`GTXHP_WM2_RST);
      end else begin
         if (port.reg_wr && port.reg_addr < 8'(`GTXHP_NREG_CFG) && port.reg_addr != `GTXHP_REG_STAT_IDX) begin
            regs_q[port.reg_addr] <= port.reg_wdata;
         end
         regs_q[`GTXHP_REG_STAT_IDX] <= {4'h0, drop_q, used_q};
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) rdata_q <= 16'h0000;
      else if (port.reg_rd) rdata_q <= (port.reg_addr < 8'(`GTXHP_NREG)) ? regs_q[port.reg_addr] : 16'h0000;
   end
   assign port.reg_rdata = rdata_q;

   // Control travels with the first word, so queued packets keep their own choice
   logic fcs_on;
   assign fcs_on = regs_q[`GTXHP_REG_CFG_IDX][`GTXHP_CFG_FCS_BIT] || !head[38];

   gtxhp_framer u_framer (
      .clk_sys    (clk_sys),
      .nrst       (nrst),
      .start      (f_start),
      .add_fcs    (pause_q ? 1'b1 : fcs_on),
      .add_pad    (pause_q | regs_q[`GTXHP_REG_CFG_IDX][`GTXHP_CFG_PAD_BIT]),
      .byte_valid (src_pause_q ? 1'b1 : f_valid),
      .byte_data  (f_byte),
      .byte_last  (f_last && (src_pause_q || fifo_pop)),
      .byte_ready (f_ready),
      .busy       (f_busy),
      .line_valid (line_valid),
      .line_byte  (line_byte)
   );

   // Frame classification on the outgoing byte stream
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         flen_q          <= 11'h000;
         lt_q            <= 16'h0000;
         frame_undersize <= 1'b0;
         frame_oversize  <= 1'b0;
         frame_lt_kind   <= GTXHP_LT_LENGTH;
         frame_da_kind   <= GTXHP_DA_UNICAST;
      end else if (f_start) begin
         flen_q <= 11'h000;
      end else if (f_ready && (src_pause_q ? 1'b1 : f_valid)) begin
         flen_q <= (flen_q == 11'h7FF) ? flen_q : flen_q + 11'h001;
         if (flen_q == 11'h000) begin
            frame_da_kind <= !f_byte[0] ? GTXHP_DA_UNICAST :
                             (f_byte == 8'hFF) ? GTXHP_DA_BROADCAST : GTXHP_DA_MULTICAST;
         end
         if (flen_q == 11'h00C) lt_q[15:8] <= f_byte;
         if (flen_q == 11'h00D) begin
            lt_q[7:0]     <= f_byte;
            frame_lt_kind <= ({lt_q[15:8], f_byte} <= `GTXHP_LEN_MAX) ? GTXHP_LT_LENGTH :
                             ({lt_q[15:8], f_byte} < `GTXHP_TYPE_MIN) ? GTXHP_LT_UNDEF : GTXHP_LT_TYPE;
         end
         if (f_last) begin
            frame_undersize <= (flen_q + 11'h001 + `GTXHP_CRC_BYTES < `GTXHP_MIN_FRAME);
            frame_oversize  <= (flen_q + 11'h001 + `GTXHP_CRC_BYTES > `GTXHP_MAX_FRAME);
         end
      end
   end
endmodule

// File: gtxhp_framer.sv
// Serial frame builder: lead-in, padding, frame check and gap around byte stream
`timescale 1ns/1ps
`include "gtxhp_consts.svh"
module gtxhp_framer
   import gtxhp_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        start,
   input  wire logic        add_fcs,
   input  wire logic        add_pad,
   input  wire logic        byte_valid,
   input  wire logic [7:0]  byte_data,
   input  wire logic        byte_last,
   output logic             byte_ready,
   output logic             busy,
   output logic             line_valid,
   output logic [7:0]       line_byte
);
   gtxhp_tx_t   state_q;
   logic [10:0] cnt_q;
   logic [3:0]  sub_q;
   logic [31:0] crc_q;
   logic        fcs_q;
   logic        pad_q;

   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
      logic [31:0] r;
      r = c ^ {24'h000000, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `GTXHP_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   assign busy       = (state_q != GTXHP_TX_IDLE);
   assign byte_ready = (state_q == GTXHP_TX_DATA);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q <= GTXHP_TX_IDLE;
         cnt_q   <= 11'h000;
         sub_q   <= 4'h0;
         fcs_q   <= 1'b0;
         pad_q   <= 1'b0;
      end else begin
         unique case (state_q)
            GTXHP_TX_IDLE: if (start) begin
               state_q <= GTXHP_TX_PRE;
               sub_q   <= 4'h0;
               cnt_q   <= 11'h000;
               fcs_q   <= add_fcs;
               pad_q   <= add_pad;
            end
            GTXHP_TX_PRE: begin
               sub_q <= sub_q + 4'h1;
               if (sub_q == `GTXHP_PRE_BYTES) begin
                  state_q <= GTXHP_TX_DATA;
               end
            end
            GTXHP_TX_DATA: if (byte_valid) begin
               cnt_q <= cnt_q + 11'h001;
               if (byte_last) begin
                  sub_q <= 4'h0;
                  if (pad_q && (cnt_q + 11'h001 < `GTXHP_HDR_BYTES + `GTXHP_MIN_DATA)) begin
                     state_q <= GTXHP_TX_PAD;
                  end else begin
                     state_q <= fcs_q ? GTXHP_TX_FCS : GTXHP_TX_GAP;
                  end
               end
            end
            GTXHP_TX_PAD: begin
               cnt_q <= cnt_q + 11'h001;
               if (cnt_q + 11'h001 == `GTXHP_HDR_BYTES + `GTXHP_MIN_DATA) begin
                  state_q <= fcs_q ? GTXHP_TX_FCS : GTXHP_TX_GAP;
               end
            end
            GTXHP_TX_FCS: begin
               sub_q <= sub_q + 4'h1;
               if (sub_q == 4'h3) begin
                  state_q <= GTXHP_TX_GAP;
                  sub_q   <= 4'h0;
               end
            end
            GTXHP_TX_GAP: begin
               sub_q <= sub_q + 4'h1;
               if (sub_q == `GTXHP_IPG_BYTES - 4'h1) begin
                  state_q <= GTXHP_TX_IDLE;
               end
            end
            default: state_q <= GTXHP_TX_IDLE;
         endcase
      end
   end

   // Frame check covers address through padding, never lead-in
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         crc_q <= `GTXHP_CRC_INIT;
      end else if (state_q == GTXHP_TX_PRE) begin
         crc_q <= `GTXHP_CRC_INIT;
      end else if (state_q == GTXHP_TX_DATA && byte_valid) begin
         crc_q <= crc_byte(crc_q, byte_data);
      end else if (state_q == GTXHP_TX_PAD) begin
         crc_q <= crc_byte(crc_q, 8'h00);
      end else if (state_q == GTXHP_TX_FCS) begin
         crc_q <= {8'h00, crc_q[31:8]};
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         line_valid <= 1'b0;
         line_byte  <= 8'h00;
      end else begin
         line_valid <= 1'b1;
         unique case (state_q)
            GTXHP_TX_PRE:  line_byte <= (sub_q == `GTXHP_PRE_BYTES) ? `GTXHP_SFD_BYTE : `GTXHP_PRE_BYTE;
            GTXHP_TX_DATA: begin
               line_byte  <= byte_data;
               line_valid <= byte_valid;
            end
            GTXHP_TX_PAD:  line_byte <= 8'h00;
            GTXHP_TX_FCS:  line_byte <= ~crc_q[7:0];
            default: begin
               line_byte  <= 8'h00;
               line_valid <= 1'b0;
            end
         endcase
      end
   end
endmodule

// File: gtxhp_host.sv
// Host end: pushes packet words and drives control lines from user requests
`timescale 1ns/1ps
`include "gtxhp_consts.svh"
module gtxhp_host
   import gtxhp_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   gtxhp_if.host            port,
   input  wire logic        usr_valid,
   input  wire logic [31:0] usr_data,
   input  wire logic [3:0]  usr_byte_valid,
   input  wire logic        usr_first,
   input  wire logic        usr_last,
   input  wire logic        usr_no_fcs,
   input  wire logic        usr_pause,
   input  wire logic        usr_drop_clear,
   input  wire logic        usr_reg_wr,
   input  wire logic        usr_reg_rd,
   input  wire logic [7:0]  usr_reg_addr,
   input  wire logic [15:0] usr_reg_wdata,
   output logic [15:0]      usr_reg_rdata,
   output logic             usr_level1,
   output logic             usr_level2,
   output logic             usr_dropped
);
   // Outputs registered so the device samples them on the next edge
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         port.tx_select_n        <= 1'b1;
         port.tx_data            <= 32'h00000000;
         port.tx_byte_valid      <= 4'h0;
         port.tx_first_word      <= 1'b0;
         port.tx_last_word       <= 1'b0;
         port.pkt_fcs_ctrl_n     <= 1'b0;
         port.pause_request      <= 1'b0;
         port.tx_drop_flag_clear <= 1'b0;
         port.reg_wr             <= 1'b0;
         port.reg_rd             <= 1'b0;
         port.reg_addr           <= 8'h00;
         port.reg_wdata          <= 16'h0000;
      end else begin
         port.tx_select_n        <= !usr_valid;
         port.tx_data            <= usr_data;
         // Never empty byte valid on a marker word
         port.tx_byte_valid      <= ((usr_first || usr_last) && usr_byte_valid == 4'h0) ? 4'h1 : usr_byte_valid;
         port.tx_first_word      <= usr_valid && usr_first;
         port.tx_last_word       <= usr_valid && usr_last;
         port.pkt_fcs_ctrl_n     <= usr_no_fcs;
         port.pause_request      <= usr_pause;
         port.tx_drop_flag_clear <= usr_drop_clear;
         port.reg_wr             <= usr_reg_wr;
         port.reg_rd             <= usr_reg_rd && !usr_reg_wr;
         port.reg_addr           <= usr_reg_addr;
         port.reg_wdata          <= usr_reg_wdata;
      end
   end

   assign usr_reg_rdata = port.reg_rdata;
   assign usr_level1    = !port.tx_level_flag1_n;
   assign usr_level2    = !port.tx_level_flag2_n;
   assign usr_dropped   = port.tx_drop_flag;
endmodule

// File: gtxhp_if.sv
// Transmit host packet port signals between host logic and the device
`timescale 1ns/1ps
interface gtxhp_if;
   logic        tx_select_n;
   logic [31:0] tx_data;
   logic [3:0]  tx_byte_valid;
   logic        tx_first_word;
   logic        tx_last_word;
   logic        pkt_fcs_ctrl_n;
   logic        pause_request;
   logic        tx_drop_flag_clear;
   logic        tx_level_flag1_n;
   logic        tx_level_flag2_n;
   logic        tx_drop_flag;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   modport device (
      input  tx_select_n, tx_data, tx_byte_valid, tx_first_word, tx_last_word, pkt_fcs_ctrl_n,
             pause_request, tx_drop_flag_clear, reg_wr, reg_rd, reg_addr, reg_wdata,
      output tx_level_flag1_n, tx_level_flag2_n, tx_drop_flag, reg_rdata
   );
   modport host (
      output tx_select_n, tx_data, tx_byte_valid, tx_first_word, tx_last_word, pkt_fcs_ctrl_n,
             pause_request, tx_drop_flag_clear, reg_wr, reg_rd, reg_addr, reg_wdata,
      input  tx_level_flag1_n, tx_level_flag2_n, tx_drop_flag, reg_rdata
   );
endinterface

// File: gtxhp_pkg.sv
// Types for the transmit host packet port
package gtxhp_pkg;
   typedef enum logic [1:0] {GTXHP_LT_LENGTH, GTXHP_LT_UNDEF, GTXHP_LT_TYPE} gtxhp_lt_t;
   typedef enum logic [1:0] {GTXHP_DA_UNICAST, GTXHP_DA_MULTICAST, GTXHP_DA_BROADCAST} gtxhp_da_t;
   typedef enum logic [2:0] {GTXHP_TX_IDLE, GTXHP_TX_PRE, GTXHP_TX_DATA, GTXHP_TX_PAD,
                             GTXHP_TX_FCS, GTXHP_TX_GAP} gtxhp_tx_t;
endpackage

// File: gtxhp_port_sva.sv
// Concurrent checks on the signals between host and device ends
`timescale 1ns/1ps
module gtxhp_port_sva (
   input wire logic        clk_sys,
   input wire logic        nrst,
   input wire logic        tx_select_n,
   input wire logic [3:0]  tx_byte_valid,
   input wire logic        tx_first_word,
   input wire logic        tx_last_word,
   input wire logic        tx_drop_flag_clear,
   input wire logic        tx_level_flag1_n,
   input wire logic        tx_level_flag2_n,
   input wire logic        tx_drop_flag,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   a_rst_idle: assert property ($rose(nrst) |-> tx_select_n && tx_level_flag1_n && !tx_drop_flag)
      else $error("port not idle after reset");
   a_drop_clear: assert property (tx_drop_flag_clear && tx_select_n |=> !tx_drop_flag)
      else $error("drop flag not cleared");
   a_drop_latch: assert property (tx_drop_flag && !tx_drop_flag_clear && tx_select_n |=> tx_drop_flag)
      else $error("drop flag not held");
   a_drop_cause: assert property ($rose(tx_drop_flag) |-> !$past(tx_select_n))
      else $error("drop flag set with port deselected");
   a_lvl1_cause: assert property ($fell(tx_level_flag1_n) |-> !$past(tx_select_n) || !$past(tx_select_n, 2)
      || $past(reg_wr) || $past(reg_wr, 2)) else $error("level flag 1 rose without a stored word");
   a_lvl2_cause: assert property ($fell(tx_level_flag2_n) |-> !$past(tx_select_n) || !$past(tx_select_n, 2)
      || $past(reg_wr) || $past(reg_wr, 2)) else $error("level flag 2 rose without a stored word");
   a_level_order: assert property (!tx_level_flag2_n |-> !tx_level_flag1_n)
      else $error("upper level flag without lower");
   a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data changed without a read");
   a_marker_lanes: assert property (!tx_select_n && (tx_first_word || tx_last_word) |-> tx_byte_valid != 4'h0)
      else $error("frame marker with no valid lane");
endmodule
